// ### rid_robot_input_dispatcher.v
/*
  Input function dispatcher of a robot controller: turns direct-terminal and remote-bit
  input functions into excitation, stop, program, homing, limit, relay and inching actions.
  Assumes function vectors already decoded per source, an APB master on pclk, and an
  executor on pclk that reports command completion and program end.
*/
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "rid_regs.vh"

module rid_robot_input_dispatcher
(
  // clock and reset
  input  wire                    pclk,
  input  wire                    presetn,
  // apb slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [7:0]              paddr,
  input  wire [31:0]             pwdata,
  output reg                     pready,
  output reg  [31:0]             prdata,
  output reg                     pslverr,
  // input functions from direct terminals and remote bits
  input  wire [`RID_NCTL-1:0]    direct_ctl,
  input  wire [`RID_NCTL-1:0]    remote_ctl,
  input  wire [`RID_NLAUNCH-1:0] direct_program_launch,
  input  wire [`RID_NLAUNCH-1:0] remote_program_launch,
  input  wire [`RID_NSEL-1:0]    direct_program_select_bits,
  input  wire [`RID_NSEL-1:0]    remote_program_select_bits,
  input  wire [`RID_NWAIT-1:0]   direct_wait_inputs,
  input  wire [`RID_NWAIT-1:0]   remote_wait_inputs,
  input  wire [`RID_NRELAY-1:0]  relay_inputs_remote,
  input  wire [`RID_NRELAY-1:0]  relay_inputs_direct,
  input  wire [`RID_NINCH-1:0]   direct_inching_request,
  input  wire [`RID_NINCH-1:0]   remote_inching_request,
  // executor feedback
  input  wire                    cmd_complete,
  input  wire                    prog_end,
  input  wire                    user_origin_set,
  // motor control
  output reg                     excite_robot,
  output reg                     excite_effector1,
  output reg                     excite_effector2,
  output reg                     brake_release_robot,
  output reg                     brake_release_effector1,
  output reg                     brake_release_effector2,
  output reg                     motor_halt,
  output reg                     current_limit,
  output reg                     speed_limit,
  // program control
  output reg                     prog_abort,
  output reg                     prog_start,
  output reg                     step_mode,
  output reg                     step_go,
  output reg                     pause_hold,
  output reg                     prog_resume,
  output reg  [`RID_NSEL-1:0]    prog_number,
  output reg                     command_completed,
  output reg  [3:0]              home_req,
  output reg                     home_refused,
  output reg  [`RID_NINCH-1:0]   inching_pulse,
  // pass-through and wait conditions
  output reg  [`RID_NWAIT-1:0]   wait_direct,
  output reg  [`RID_NWAIT-1:0]   wait_remote,
  output reg  [`RID_NRELAY-1:0]  relay_output_terminal,
  output reg  [`RID_NRELAY-1:0]  remote_output_bit,
  output reg                     operator_unlock
);

  // ****************************************
  // synchronised input vector
  // ****************************************
  localparam NC = `RID_NCTL;
  localparam NL = `RID_NLAUNCH;
  localparam NS = `RID_NSEL;
  localparam NW = `RID_NWAIT;
  localparam NR = `RID_NRELAY;
  localparam NI = `RID_NINCH;
  localparam W  = 2*NC + 2*NL + 2*NS + 2*NW + 2*NR + 2*NI;

  localparam ST_IDLE = 4'h1;
  localparam ST_AUTO = 4'h2;
  localparam ST_STEP = 4'h4;
  localparam ST_WAIT = 4'h8;

  wire [W-1:0] raw_in;
  wire [W-1:0] syn;

  assign raw_in = {remote_inching_request, direct_inching_request,
                   relay_inputs_direct, relay_inputs_remote,
                   remote_wait_inputs, direct_wait_inputs,
                   remote_program_select_bits, direct_program_select_bits,
                   remote_program_launch, direct_program_launch,
                   remote_ctl, direct_ctl};

  rid_sync3 #(.W(W)) u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (raw_in),
    .dout    (syn)
  );

  wire [NC-1:0] s_dctl;
  wire [NC-1:0] s_rctl;
  wire [NL-1:0] s_dl;
  wire [NL-1:0] s_rl;
  wire [NS-1:0] s_dsel;
  wire [NS-1:0] s_rsel;
  wire [NW-1:0] s_dwait;
  wire [NW-1:0] s_rwait;
  wire [NR-1:0] s_rrel;
  wire [NR-1:0] s_drel;
  wire [NI-1:0] s_dinch;
  wire [NI-1:0] s_rinch;

  assign {s_rinch, s_dinch, s_drel, s_rrel, s_rwait, s_dwait,
          s_rsel, s_dsel, s_rl, s_dl, s_rctl, s_dctl} = syn;

  // ****************************************
  // configuration registers
  // ****************************************
  reg  [`RID_CFG_W-1:0] cfg;
  reg  [31:0]           launch_lo;
  reg  [31:0]           launch_hi;
  reg  [3:0]            state;

  wire cartesian  = cfg[`RID_CFG_CARTESIAN];
  wire ehalt_map  = cfg[`RID_CFG_EHALT_MAP];
  wire unl_dmap   = cfg[`RID_CFG_UNL_DMAP];
  wire unl_rmap   = cfg[`RID_CFG_UNL_RMAP];

  // ****************************************
  // combined functions and edges
  // ****************************************
  wire [NC-1:0] ctl    = s_dctl | s_rctl;
  wire [NL-1:0] launch = s_dl | s_rl;
  wire [NI-1:0] inch   = s_dinch | s_rinch;
  wire [NS-1:0] sel    = s_dsel | s_rsel;

  reg  [NC-1:0] ctl_q;
  reg  [NL-1:0] launch_q;
  reg  [NI-1:0] inch_q;
  reg           ehalt_q;

  wire [NC-1:0] ctl_rise    = ctl & ~ctl_q;
  wire [NC-1:0] ctl_fall    = ~ctl & ctl_q;
  wire [NL-1:0] launch_rise = launch & ~launch_q;
  wire [NI-1:0] inch_rise   = inch & ~inch_q;

  // emergency halt only from direct terminals, on when not mapped
  wire ehalt_ok   = ehalt_map ? s_dctl[`RID_F_EHALT] : 1'b1;
  wire ehalt_drop = ~ehalt_ok & ehalt_q;

  wire stop_on    = ctl[`RID_F_STOP];
  wire stop_rise  = ctl_rise[`RID_F_STOP];
  wire halt_level = stop_on | ~ehalt_ok;
  wire halt_req   = stop_rise | ehalt_drop | (~ehalt_ok & ~state[0]);
  wire paused     = ctl[`RID_F_PAUSE];

  wire run_rise   = ctl_rise[`RID_F_RUN];
  wire step_rise  = ctl_rise[`RID_F_STEP];
  wire can_start  = ~halt_level & ~paused;

  reg  [NS-1:0] launch_prog;
  integer k;
  always @*
  begin
    launch_prog = {NS{1'b0}};
    for (k = NL - 1; k >= 0; k = k - 1)
    begin
      if (launch_rise[k])
      begin
        if (k < 4)
          launch_prog = launch_lo[k*8 +: NS];
        else
          launch_prog = launch_hi[(k-4)*8 +: NS];
      end
    end
  end

  wire any_launch = |launch_rise;

  // ****************************************
  // program sequencing
  // ****************************************
  reg [3:0] next_state;
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (can_start & step_rise)
          next_state = ST_STEP;
        else if (can_start & (run_rise | any_launch))
          next_state = ST_AUTO;
      end
      ST_AUTO:
      begin
        if (prog_end)
          next_state = ST_IDLE;
      end
      ST_STEP:
      begin
        if (prog_end)
          next_state = ST_IDLE;
        else if (cmd_complete)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (can_start & step_rise)
          next_state = ST_STEP;
      end
      default:
        next_state = ST_IDLE;
    endcase
    if (halt_req)
      next_state = ST_IDLE;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= ST_IDLE;
      ctl_q       <= {NC{1'b0}};
      launch_q    <= {NL{1'b0}};
      inch_q      <= {NI{1'b0}};
      ehalt_q     <= 1'b1;
      prog_abort  <= 1'b0;
      prog_start  <= 1'b0;
      step_mode   <= 1'b0;
      step_go     <= 1'b0;
      pause_hold  <= 1'b0;
      prog_resume <= 1'b0;
      prog_number <= {NS{1'b0}};
      command_completed <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      ctl_q    <= ctl;
      launch_q <= launch;
      inch_q   <= inch;
      ehalt_q  <= ehalt_ok;
      prog_abort  <= halt_req & ~state[0];
      prog_start  <= state[0] & ~next_state[0];
      step_go     <= next_state[2] & ~state[2];
      pause_hold  <= paused & ~state[0];
      prog_resume <= ctl_fall[`RID_F_PAUSE] & ~state[0] & ~halt_req;
      command_completed <= cmd_complete & ~halt_level & ~halt_req;
      if (state[0] & ~next_state[0])
      begin
        step_mode <= next_state[2];
        if (~step_rise & ~run_rise)
          prog_number <= launch_prog;
        else
          prog_number <= sel;
      end
    end
  end

  // ****************************************
  // motor, homing, limit and pass-through outputs
  // ****************************************
  wire rel_all = ctl[`RID_F_FREE_ALL];
  wire rel_rb  = rel_all | ctl[`RID_F_ROBOT_REL];
  wire rel_e1  = rel_all | ctl[`RID_F_EFF1_REL];
  wire rel_e2  = rel_all | ctl[`RID_F_EFF2_REL];
  wire home_ok = cartesian | user_origin_set;
  wire [3:0] home_rise = ctl_rise[`RID_F_HOME_E2:`RID_F_HOME_ALL];

  reg unlock_now;
  always @*
  begin
    case ({unl_dmap, unl_rmap})
      2'b11:   unlock_now = s_dctl[`RID_F_UNLOCK] & s_rctl[`RID_F_UNLOCK];
      2'b10:   unlock_now = s_dctl[`RID_F_UNLOCK];
      2'b01:   unlock_now = s_rctl[`RID_F_UNLOCK];
      default: unlock_now = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      excite_robot            <= 1'b0;
      excite_effector1        <= 1'b0;
      excite_effector2        <= 1'b0;
      brake_release_robot     <= 1'b0;
      brake_release_effector1 <= 1'b0;
      brake_release_effector2 <= 1'b0;
      motor_halt              <= 1'b1;
      current_limit           <= 1'b0;
      speed_limit             <= 1'b0;
      home_req                <= 4'h0;
      home_refused            <= 1'b0;
      inching_pulse           <= {NI{1'b0}};
      wait_direct             <= {NW{1'b0}};
      wait_remote             <= {NW{1'b0}};
      relay_output_terminal   <= {NR{1'b0}};
      remote_output_bit       <= {NR{1'b0}};
      operator_unlock         <= 1'b0;
    end
    else
    begin
      excite_robot            <= ~rel_rb;
      excite_effector1        <= ~rel_e1;
      excite_effector2        <= ~rel_e2;
      brake_release_robot     <= rel_rb;
      brake_release_effector1 <= rel_e1;
      brake_release_effector2 <= rel_e2;
      motor_halt              <= halt_level | halt_req | paused;
      current_limit <= |ctl[`RID_F_CUR_HI:`RID_F_CUR_LO];
      speed_limit   <= |ctl[`RID_F_SPD_HI:`RID_F_SPD_LO];
      home_req      <= home_rise & {4{home_ok & ~halt_level}};
      home_refused  <= (|home_rise) & ~home_ok;
      inching_pulse <= inch_rise & {NI{~halt_level}};
      wait_direct   <= s_dwait;
      wait_remote   <= s_rwait;
      relay_output_terminal <= s_rrel;
      remote_output_bit     <= s_drel;
      operator_unlock       <= unlock_now;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  wire       setup   = psel & ~penable;
  wire       wr_acc  = psel & penable & pready & pwrite;
  wire [7:0] ofs     = paddr;
  wire       hit     = (ofs == `RID_OFS_CFG) | (ofs == `RID_OFS_LAUNCH_LO) |
                       (ofs == `RID_OFS_LAUNCH_HI) | (ofs == `RID_OFS_STATUS);
  wire       ro_hit  = (ofs == `RID_OFS_STATUS);

  reg [31:0] rd_mux;
  always @*
  begin
    case (ofs)
      `RID_OFS_CFG:       rd_mux = {{(32-`RID_CFG_W){1'b0}}, cfg};
      `RID_OFS_LAUNCH_LO: rd_mux = launch_lo;
      `RID_OFS_LAUNCH_HI: rd_mux = launch_hi;
      `RID_OFS_STATUS:    rd_mux = {12'h000, operator_unlock, motor_halt, pause_hold,
                                    step_mode, 2'h0, prog_number, 4'h0, state};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready    <= 1'b0;
      prdata    <= 32'h00000000;
      pslverr   <= 1'b0;
      cfg       <= `RID_CFG_RST;
      launch_lo <= `RID_LAUNCH_RST;
      launch_hi <= `RID_LAUNCH_RST_HI;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & (~hit | (pwrite & ro_hit));
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (wr_acc & ~pslverr)
      begin
        if (ofs == `RID_OFS_CFG)
          cfg <= pwdata[`RID_CFG_W-1:0];
        if (ofs == `RID_OFS_LAUNCH_LO)
          launch_lo <= pwdata & 32'h3F3F3F3F;
        if (ofs == `RID_OFS_LAUNCH_HI)
          launch_hi <= pwdata & 32'h3F3F3F3F;
      end
    end
  end

endmodule // rid_robot_input_dispatcher

// ### rid_regs.vh
/*
  Constants of the robot input dispatcher: function slot positions, register offsets,
  field positions and reset values.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef RID_REGS_VH
`define RID_REGS_VH

// ****************************************
// widths
// ****************************************
`define RID_NCTL           20
`define RID_NLAUNCH        8
`define RID_NSEL           6
`define RID_NWAIT          16
`define RID_NRELAY         16
`define RID_NINCH          32

// ****************************************
// control function slots
// ****************************************
`define RID_F_FREE_ALL     0
`define RID_F_ROBOT_REL    1
`define RID_F_EFF1_REL     2
`define RID_F_EFF2_REL     3
`define RID_F_STOP         4
`define RID_F_EHALT        5
`define RID_F_PAUSE        6
`define RID_F_RUN          7
`define RID_F_STEP         8
`define RID_F_HOME_ALL     9
`define RID_F_HOME_ROBOT   10
`define RID_F_HOME_E1      11
`define RID_F_HOME_E2      12
`define RID_F_UNLOCK       13
`define RID_F_CUR_LO       14
`define RID_F_CUR_HI       16
`define RID_F_SPD_LO       17
`define RID_F_SPD_HI       19

// ****************************************
// register offsets
// ****************************************
`define RID_OFS_CFG        8'h00
`define RID_OFS_LAUNCH_LO  8'h04
`define RID_OFS_LAUNCH_HI  8'h08
`define RID_OFS_STATUS     8'h0C

// ****************************************
// configuration fields and reset values
// ****************************************
`define RID_CFG_CARTESIAN  0
`define RID_CFG_EHALT_MAP  1
`define RID_CFG_UNL_DMAP   2
`define RID_CFG_UNL_RMAP   3
`define RID_CFG_W          4
`define RID_CFG_RST        4'h0
`define RID_LAUNCH_RST     32'h03020100
`define RID_LAUNCH_RST_HI  32'h07060504

`endif

// ### rid_sync3.v
/*
  Three-stage input synchroniser, one chain per bit.
  Assumes asynchronous inputs; the output follows once stages two and three agree.
*/
`timescale 1ns/10ps

module rid_sync3
#(
  parameter W = 8
)
(
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1[i]   <= 1'b0;
          s2[i]   <= 1'b0;
          s3[i]   <= 1'b0;
          dout[i] <= 1'b0;
        end
        else
        begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i])
            dout[i] <= s3[i];
        end
      end
    end
  endgenerate

endmodule // rid_sync3

// ### rid_props.sv
/*
  Concurrent checks on the robot input dispatcher ports.
  Assumes one clock pclk, presetn async active low, five-edge input latency.
*/
`timescale 1ns/10ps
`include "rid_regs.vh"

module rid_props
(
  // clock and reset
  input logic                   pclk,
  input logic                   presetn,
  // input functions
  input logic [`RID_NCTL-1:0]   direct_ctl,
  input logic [`RID_NCTL-1:0]   remote_ctl,
  input logic [`RID_NRELAY-1:0] relay_inputs_remote,
  input logic [`RID_NWAIT-1:0]  direct_wait_inputs,
  // actions
  input logic                   excite_robot,
  input logic                   excite_effector1,
  input logic                   excite_effector2,
  input logic                   brake_release_robot,
  input logic                   brake_release_effector2,
  input logic                   motor_halt,
  input logic                   current_limit,
  input logic                   command_completed,
  input logic [`RID_NRELAY-1:0] relay_output_terminal,
  input logic [`RID_NWAIT-1:0]  wait_direct
);
  // ****************************************
  // properties
  // ****************************************
  wire [`RID_NCTL-1:0] f = direct_ctl | remote_ctl;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_on6(logic b);
    b [*6];
  endsequence
  chk_all_release : assert property (s_on6(f[0]) |-> !excite_robot && !excite_effector1 && !excite_effector2)
    else $error("all-axes release left a motor excited");
  chk_robot_release : assert property (s_on6(f[1] && !f[0] && !f[2]) |-> !excite_robot && excite_effector1)
    else $error("robot release handled the effector wrongly");
  chk_eff2_release : assert property (s_on6(f[3] && !f[0]) |-> !excite_effector2 && brake_release_effector2)
    else $error("effector two release not applied");
  chk_brake_free : assert property (s_on6(f[1]) |-> brake_release_robot)
    else $error("robot brake not released");
  chk_stop_nodone : assert property (s_on6(f[4]) |-> !command_completed)
    else $error("command completed during stop");
  chk_stop_halt : assert property (s_on6(f[4]) |-> motor_halt)
    else $error("stop did not halt motors");
  chk_pause_halt : assert property (s_on6(f[6]) |-> motor_halt)
    else $error("pause did not hold motors");
  chk_cur_limit : assert property (s_on6(f[14] || f[15] || f[16]) |-> current_limit)
    else $error("current limit not applied");
  chk_relay_copy : assert property ($stable(relay_inputs_remote) [*6] |-> relay_output_terminal == relay_inputs_remote)
    else $error("relay output differs from host bits");
  chk_wait_copy : assert property ($stable(direct_wait_inputs) [*6] |-> wait_direct == direct_wait_inputs)
    else $error("direct wait inputs not passed on");
endmodule // rid_props

bind rid_robot_input_dispatcher rid_props u_props (.pclk, .presetn, .direct_ctl, .remote_ctl, .relay_inputs_remote,
  .direct_wait_inputs, .excite_robot, .excite_effector1, .excite_effector2, .brake_release_robot,
  .brake_release_effector2, .motor_halt, .current_limit, .command_completed, .relay_output_terminal, .wait_direct);

// ### rid_exec_model.sv
/*
  Behavioural program executor on the far side of the dispatcher.
  Assumes same-clock pulses; a run lasts 40 cycles, a step 4, two steps end a program.
*/
`timescale 1ns/10ps

module rid_exec_model
(
  // clock and reset
  input  logic pclk,
  input  logic presetn,
  // commands
  input  logic prog_start,
  input  logic step_go,
  input  logic prog_abort,
  input  logic pause_hold,
  input  logic motor_halt,
  // feedback
  output logic cmd_complete,
  output logic prog_end
);
  // ****************************************
  // command timing
  // ****************************************
  logic       auto_run;
  logic [1:0] steps;
  logic [5:0] cnt;
  wire        last = cnt == 6'h1 && (auto_run || steps == 2'h2);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_run <= 1'h0;
      steps <= 2'h0;
      cnt <= 6'h0;
      cmd_complete <= 1'h0;
      prog_end <= 1'h0;
    end
    else
    begin
      cmd_complete <= cnt == 6'h1;
      prog_end <= last;
      if (prog_abort)
        cnt <= 6'h0;
      else if (step_go)
      begin
        // one command per step request
        cnt <= 6'h4;
        steps <= steps + 2'h1;
        auto_run <= 1'h0;
      end
      else if (prog_start)
      begin
        cnt <= 6'h28;
        auto_run <= 1'h1;
      end
      else if (cnt == 6'h1)
      begin
        cnt <= 6'h0;
        if (last)
          steps <= 2'h0;
      end
      else if (cnt != 6'h0 && !pause_hold && !motor_halt)
        cnt <= cnt - 6'h1;
    end
  end
endmodule // rid_exec_model

// ### rid_robot_input_dispatcher_tb.sv
/*
  Self-checking bench of the robot input dispatcher.
  Assumes an APB master on pclk and the executor model on the far side.
*/
`timescale 1ns/10ps
`include "rid_regs.vh"

module rid_robot_input_dispatcher_tb;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, user_origin_set = 1'h0;
  logic [7:0]  paddr = 8'h0, direct_program_launch = 8'h0, remote_program_launch = 8'h0;
  logic [31:0] pwdata = 32'h0, direct_inching_request = 32'h0, remote_inching_request = 32'h0;
  logic [19:0] direct_ctl = 20'h0, remote_ctl = 20'h0;
  logic [5:0]  direct_program_select_bits = 6'h0, remote_program_select_bits = 6'h0, prog_number;
  logic [15:0] direct_wait_inputs = 16'h0, remote_wait_inputs = 16'h0, relay_inputs_remote = 16'h0;
  logic [15:0] relay_inputs_direct = 16'h0, wait_direct, wait_remote, relay_output_terminal, remote_output_bit;
  logic [31:0] prdata, rv, inching_pulse;
  logic        pready, pslverr, ev_e, cmd_complete, prog_end, excite_robot, excite_effector1, excite_effector2;
  logic        brake_release_robot, brake_release_effector1, brake_release_effector2, motor_halt, current_limit;
  logic        speed_limit, prog_abort, prog_start, step_mode, step_go, pause_hold, prog_resume;
  logic        command_completed, home_refused, operator_unlock;
  logic [3:0]  home_req;
  int          errors = 0, check_count = 0, n, k;
  wire [6:0]   ev = {home_refused, |home_req, |inching_pulse, prog_resume, step_go, prog_abort, prog_start};
  always #4 pclk = ~pclk;
  rid_robot_input_dispatcher dut (.*);
  rid_exec_model u_exec (.pclk(pclk), .presetn(presetn), .prog_start(prog_start), .step_go(step_go),
    .prog_abort(prog_abort), .pause_hold(pause_hold), .motor_halt(motor_halt), .cmd_complete(cmd_complete),
    .prog_end(prog_end));

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge pclk);
  endtask
  task automatic wt(input int b);
    for (n = 0; n < 400 && ev[b] !== 1'h1; n++) @(negedge pclk);
    if (ev[b] !== 1'h1)
    begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    c = 0;
    do begin @(posedge pclk); c++; end while (pready !== 1'h1 && c < 50);
    rv = prdata;
    ev_e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (c >= 50)
    begin
      errors++;
      $display("[ERR] %0t no pready", $time);
      give_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'h0, a, 32'h0);
    chk(rv, x);
    chk(ev_e, xe);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(1'h1, a, d);
    chk(ev_e, xe);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rd(`RID_OFS_CFG, 32'h0, 1'h0);
    rd(`RID_OFS_STATUS, 32'h00080001, 1'h0);
    rd(`RID_OFS_LAUNCH_HI, `RID_LAUNCH_RST_HI, 1'h0);
    rd(8'h10, 32'h0, 1'h1);
    wr(`RID_OFS_STATUS, 32'hFFFFFFFF, 1'h1);
    wr(`RID_OFS_LAUNCH_HI, 32'hFF1A0504, 1'h0);
    rd(`RID_OFS_LAUNCH_HI, 32'h3F1A0504, 1'h0);
    $display("test registers finished");
    for (k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      if (k[0]) remote_ctl[k] <= 1'h1; else direct_ctl[k] <= 1'h1;
      cyc(8);
      chk({excite_robot, excite_effector1, excite_effector2}, 12'hD58 >> (3 * k) & 7);
      chk({brake_release_robot, brake_release_effector1, brake_release_effector2}, ~12'hD58 >> (3 * k) & 7);
      @(posedge pclk);
      direct_ctl <= 20'h0;
      remote_ctl <= 20'h0;
      cyc(8);
    end
    $display("test release finished");
    @(posedge pclk);
    remote_program_select_bits <= 6'h2A;
    direct_ctl[7] <= 1'h1;
    wt(0);
    chk(prog_number, 6'h2A);
    @(posedge pclk);
    remote_ctl[4] <= 1'h1;
    wt(1);
    cyc(8);
    chk(motor_halt, 1'h1);
    @(posedge pclk);
    remote_ctl[4] <= 1'h0;
    direct_ctl[7] <= 1'h0;
    cyc(8);
    @(posedge pclk);
    direct_ctl[7] <= 1'h1;
    wt(0);
    @(posedge pclk);
    remote_ctl[6] <= 1'h1;
    cyc(8);
    chk({pause_hold, motor_halt}, 2'h3);
    @(posedge pclk);
    remote_ctl[6] <= 1'h0;
    wt(3);
    cyc(80);
    @(posedge pclk);
    direct_ctl[7] <= 1'h0;
    direct_program_launch[7] <= 1'h1;
    wt(0);
    chk(prog_number, 6'h3F);
    cyc(80);
    $display("test program start finished");
    @(posedge pclk);
    direct_program_launch[7] <= 1'h0;
    direct_ctl[8] <= 1'h1;
    wt(2);
    chk(step_mode, 1'h1);
    k = 0;
    repeat (30) begin @(negedge pclk); k += step_go + 16 * command_completed; end
    chk(k, 16);
    @(posedge pclk);
    direct_ctl[8] <= 1'h0;
    cyc(8);
    @(posedge pclk);
    direct_ctl[8] <= 1'h1;
    wt(2);
    cyc(20);
    $display("test step finished");
    @(posedge pclk);
    direct_ctl[8] <= 1'h0;
    direct_ctl[9] <= 1'h1;
    wt(6);
    chk(home_req, 4'h0);
    @(posedge pclk);
    direct_ctl[9] <= 1'h0;
    user_origin_set <= 1'h1;
    cyc(8);
    for (k = 0; k < 4; k++)
    begin
      if (k == 2)
        wr(`RID_OFS_CFG, 32'h1, 1'h0);
      @(posedge pclk);
      remote_ctl[9 + k] <= 1'h1;
      user_origin_set <= k < 2;
      wt(5);
      chk(home_req, 4'h1 << k);
      @(posedge pclk);
      remote_ctl[9 + k] <= 1'h0;
      cyc(8);
    end
    for (k = 0; k < 32; k++)
    begin
      @(posedge pclk);
      remote_inching_request <= 32'h1 << k;
      wt(4);
      chk(inching_pulse, 32'h1 << k);
      cyc(8);
    end
    $display("test homing and inching finished");
    @(posedge pclk);
    relay_inputs_remote <= 16'hA5C3;
    relay_inputs_direct <= 16'h5A3C;
    direct_wait_inputs <= 16'h1234;
    remote_wait_inputs <= 16'h8001;
    remote_ctl[15] <= 1'h1;
    direct_ctl[19] <= 1'h1;
    cyc(8);
    chk({relay_output_terminal, remote_output_bit}, 32'hA5C35A3C);
    chk({wait_direct, wait_remote}, 32'h12348001);
    chk({current_limit, speed_limit}, 2'h3);
    wr(`RID_OFS_CFG, 32'h2, 1'h0);
    cyc(8);
    chk(motor_halt, 1'h1);
    @(posedge pclk);
    direct_ctl[5] <= 1'h1;
    wr(`RID_OFS_CFG, 32'hE, 1'h0);
    cyc(8);
    chk({motor_halt, operator_unlock}, 2'h0);
    @(posedge pclk);
    direct_ctl[13] <= 1'h1;
    cyc(8);
    chk(operator_unlock, 1'h0);
    @(posedge pclk);
    remote_ctl[13] <= 1'h1;
    cyc(8);
    chk(operator_unlock, 1'h1);
    $display("test pass-through and interlocks finished");
    give_verdict();
  end
endmodule // rid_robot_input_dispatcher_tb
